//--- bench/serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
    // From the channels and the bench
    input  wire logic tx_a, tx_b, stop,
    // Into the channels
    output logic      rx_a, rx_b, cts_a_n, cts_b_n
);
    // An echo idles receive whenever the sender idles.
    assign {rx_a, rx_b} = {tx_a, tx_b};
    assign {cts_a_n, cts_b_n} = {2{stop}};
endmodule : serial_peer

//--- bench/serial_pins_props.sv
`timescale 1ns/100ps
module serial_pins_props (
    // Clock, reset and write response
    input wire logic CLK, SYS_RST, S_AXI_BVALID,
    // Channel pins
    input wire logic CHAN_A_SERIAL_OUT, CHAN_B_SERIAL_OUT,
    input wire logic CHAN_A_TERMINAL_READY_N, CHAN_B_TERMINAL_READY_N,
    input wire logic CHAN_A_OUTPUT_PORT2_N, CHAN_B_OUTPUT_PORT2_N,
    input wire logic CHAN_A_INTERRUPT_OE, CHAN_B_INTERRUPT_OE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Terminal-ready and interrupt-enable pins move only as a write completes.
    sequence s_wr; $rose(S_AXI_BVALID); endsequence
    property p_op2_a; CHAN_A_OUTPUT_PORT2_N != CHAN_A_INTERRUPT_OE; endproperty
    a_op2_a: assert property (p_op2_a) else $error("port2 A");
    property p_op2_b; CHAN_B_OUTPUT_PORT2_N != CHAN_B_INTERRUPT_OE; endproperty
    a_op2_b: assert property (p_op2_b) else $error("port2 B");
    property p_rst; disable iff (1'b0) SYS_RST |-> CHAN_A_SERIAL_OUT && CHAN_B_SERIAL_OUT; endproperty
    a_rst: assert property (p_rst) else $error("tx rst");
    property p_exit; $fell(SYS_RST) |-> CHAN_A_OUTPUT_PORT2_N && !CHAN_B_INTERRUPT_OE; endproperty
    a_exit: assert property (p_exit) else $error("out2 reset");
    property p_dtr_a; $changed(CHAN_A_TERMINAL_READY_N) |-> s_wr; endproperty
    a_dtr_a: assert property (p_dtr_a) else $error("dtr A");
    property p_dtr_b; $changed(CHAN_B_TERMINAL_READY_N) |-> s_wr; endproperty
    a_dtr_b: assert property (p_dtr_b) else $error("dtr B");
    property p_oe_a; $changed(CHAN_A_INTERRUPT_OE) |-> s_wr; endproperty
    a_oe_a: assert property (p_oe_a) else $error("oe A");
    property p_oe_b; $changed(CHAN_B_INTERRUPT_OE) |-> s_wr; endproperty
    a_oe_b: assert property (p_oe_b) else $error("oe B");
endmodule : serial_pins_props
bind serial_pins_top serial_pins_props u_props (.*);

//--- bench/test_uart_serial_modem_pin_interface.sv
`timescale 1ns/100ps
module test_uart_serial_modem_pin_interface
    import serial_pins_pkg::*;
;
    logic CLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, IRQ, stop;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic CHAN_A_SERIAL_OUT, CHAN_A_SERIAL_IN, CHAN_A_REQUEST_SEND_N, CHAN_A_CLEAR_SEND_N;
    logic CHAN_A_TERMINAL_READY_N, CHAN_A_SET_READY_N, CHAN_A_CARRIER_DETECT_N;
    logic CHAN_A_RING_INDICATE_N, CHAN_A_OUTPUT_PORT2_N, CHAN_A_INTERRUPT_OUT, CHAN_A_INTERRUPT_OE;
    logic CHAN_B_SERIAL_OUT, CHAN_B_SERIAL_IN, CHAN_B_REQUEST_SEND_N, CHAN_B_CLEAR_SEND_N;
    logic CHAN_B_TERMINAL_READY_N, CHAN_B_SET_READY_N, CHAN_B_CARRIER_DETECT_N;
    logic CHAN_B_RING_INDICATE_N, CHAN_B_OUTPUT_PORT2_N, CHAN_B_INTERRUPT_OUT, CHAN_B_INTERRUPT_OE;
    int   err_total, compares;

    serial_pins_top #(.BIT_CYCLES(4)) u_dut (.*);
    serial_peer u_peer (.tx_a(CHAN_A_SERIAL_OUT), .tx_b(CHAN_B_SERIAL_OUT), .stop(stop),
        .rx_a(CHAN_A_SERIAL_IN), .rx_b(CHAN_B_SERIAL_IN), .cts_a_n(CHAN_A_CLEAR_SEND_N),
        .cts_b_n(CHAN_B_CLEAR_SEND_N));

    task automatic chk(input string s, input logic [31:0] v, e);
        compares++;
        if (v !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", s, e, v);
        end
    endtask : chk

    task automatic results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // A stuck slave ends the run.
    task automatic xf(input bit w, input logic [7:0] a, input logic [31:0] d, m = '1,
                      input logic [1:0] r = RESP_OKAY);
        int n = 0;
        @(posedge CLK);
        if (w) {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'h7};
        else {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
        do begin
            @(posedge CLK);
            n++;
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!(w ? S_AXI_BVALID : S_AXI_RVALID) && n < 60);
        {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
        if (n == 60) begin
            err_total++;
            results();
        end
        chk("resp", w ? S_AXI_BRESP : S_AXI_RRESP, r);
        if (!w) chk("rdata", S_AXI_RDATA & m, d);
    endtask : xf

    task automatic pins(input string s, input logic [3:0] e);
        repeat (2) @(posedge CLK);
        chk(s, {CHAN_A_OUTPUT_PORT2_N, CHAN_A_INTERRUPT_OE, CHAN_A_TERMINAL_READY_N,
                CHAN_A_REQUEST_SEND_N}, e);
    endtask : pins

    task automatic s_pins();
        chk("tx rst", {CHAN_A_SERIAL_OUT, CHAN_B_SERIAL_OUT}, 3);
        SYS_RST <= 1'b0;
        pins("reset", 4'hB);
        xf(1, 8'h00, 32'h0B);
        pins("set", 4'h4);
        xf(1, 8'h08, 32'h40);
        xf(1, 8'h04, 32'h42);
        pins("auto", 4'h5);
        xf(1, 8'h00, 0);
        pins("clear", 4'hB);
        xf(1, CHAN_B_BASE, 32'h09);
        pins("other", 4'hB);
        chk("b pins", {CHAN_B_OUTPUT_PORT2_N, CHAN_B_TERMINAL_READY_N}, 0);
    endtask : s_pins

    task automatic s_irq();
        {CHAN_A_SET_READY_N, CHAN_A_CARRIER_DETECT_N, CHAN_A_RING_INDICATE_N} <= 3'h0;
        xf(0, 8'h0C, 32'h07, 32'h07);
        chk("irq", IRQ, 0);
        xf(1, 8'h44, 32'h04);
        pins("irq", 4'hB);
        chk("irq", {IRQ, CHAN_A_INTERRUPT_OUT}, 3);
        xf(1, 8'h40, 32'h0707);
        pins("irq", 4'hB);
        chk("irq", {IRQ, CHAN_A_INTERRUPT_OUT}, 0);
        xf(0, 8'h40, 0, 32'h07);
        xf(1, 8'h18, 1, , RESP_SLVERR);
        xf(0, 8'h18, 0, , RESP_SLVERR);
    endtask : s_irq

    task automatic s_tx();
        xf(1, 8'h04, 32'h80);
        xf(1, 8'h08, 32'h80);
        stop <= 1'b1;
        xf(1, 8'h10, 32'h55);
        repeat (30) @(posedge CLK);
        chk("held", CHAN_A_SERIAL_OUT, 1);
        stop <= 1'b0;
        repeat (60) @(posedge CLK);
        xf(0, 8'h40, 32'h10, 32'h10);
        xf(1, 8'h04, 0);
        xf(1, 8'h00, 32'h40);
        xf(0, 8'h14, 32'h02, 32'h02);
        chk("ir", {CHAN_A_SERIAL_OUT, CHAN_B_SERIAL_OUT}, 1);
        xf(1, 8'h04, 1);
        xf(0, 8'h14, 0, 32'h02);
    endtask : s_tx

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial begin
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, stop} = '0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
        S_AXI_WSTRB = 4'hF;
        SYS_RST = 1'b1;
        {CHAN_A_SET_READY_N, CHAN_A_CARRIER_DETECT_N, CHAN_A_RING_INDICATE_N} = 3'h7;
        {CHAN_B_SET_READY_N, CHAN_B_CARRIER_DETECT_N, CHAN_B_RING_INDICATE_N} = 3'h7;
        repeat (2) @(posedge CLK);
        s_pins();
        s_irq();
        s_tx();
        results();
    end
endmodule : test_uart_serial_modem_pin_interface

//--- verilog/serial_channel.sv
`timescale 1ns/100ps
module serial_channel
    import serial_pins_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Control from the register file
    input  wire chan_ctrl_type ctrl,
    input  wire logic          tx_start,
    input  wire logic [7:0]    tx_byte,
    output logic               tx_busy,
    output logic               tx_done,
    output logic               rx_level,
    // Serial pins
    input  wire logic          serial_in,
    output logic               serial_out,
    output logic               request_send_n,
    input  wire logic          clear_send_n
);

    localparam int IR_PULSE = (BIT_CYCLES * 3 / 16 < 1) ? 1 : BIT_CYCLES * 3 / 16;
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] IR_LEN   = 16'(IR_PULSE);

    typedef struct packed {
        tx_state_type state;
        logic         pending;
        logic [7:0]   shift;
        logic [2:0]   index;
        logic [15:0]  count;
        logic         line;
        logic         rx;
        logic         done;
    } chan_state_type;

    chan_state_type s_reg;
    chan_state_type s_next;
    logic           bit_val;
    logic           gate_ok;

    always_comb begin
        s_next  = s_reg;
        s_next.done = 1'b0;
        bit_val = 1'b1;
        gate_ok = !(ctrl.auto_cts && clear_send_n);
        if (tx_start) begin
            s_next.pending = 1'b1;
            s_next.shift   = tx_byte;
        end
        unique case (s_reg.state)
            TX_IDLE: begin
                bit_val = 1'b1;
                if (s_reg.pending && gate_ok) begin
                    s_next.state   = TX_START;
                    s_next.pending = tx_start;
                    s_next.count   = 16'h0000;
                end
            end
            TX_START: bit_val = 1'b0;
            TX_DATA:  bit_val = s_reg.shift[s_reg.index];
            TX_STOP:  bit_val = 1'b1;
        endcase
        if (s_reg.state != TX_IDLE) begin
            s_next.count = s_reg.count + 16'h0001;
            if (s_reg.count == BIT_LAST) begin
                s_next.count = 16'h0000;
                unique case (s_reg.state)
                    TX_START: begin
                        s_next.state = TX_DATA;
                        s_next.index = 3'h0;
                    end
                    TX_DATA: begin
                        s_next.index = s_reg.index + 3'h1;
                        if (s_reg.index == 3'h7) begin
                            s_next.state = TX_STOP;
                        end
                    end
                    TX_STOP: begin
                        s_next.state = TX_IDLE;
                        s_next.done  = 1'b1;
                    end
                    TX_IDLE: s_next.state = TX_IDLE;
                endcase
            end
        end
        if (ctrl.ir_select) begin
            // A zero bit becomes a short high pulse; ones and idle rest low.
            s_next.line = !bit_val && (s_reg.count < IR_LEN) && (s_reg.state != TX_IDLE);
            s_next.rx   = !(serial_in ^ ctrl.rx_invert);
        end else begin
            s_next.line = bit_val;
            s_next.rx   = serial_in;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg       <= '0;
            s_reg.state <= TX_IDLE;
            s_reg.line  <= 1'b1;
            s_reg.rx    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign serial_out     = s_reg.line;
    assign rx_level       = s_reg.rx;
    assign tx_busy        = (s_reg.state != TX_IDLE) || s_reg.pending;
    assign tx_done        = s_reg.done;
    // Auto flow drops the request while receive is on hold.
    assign request_send_n = !(ctrl.rts && !(ctrl.auto_rts && ctrl.rx_hold));

endmodule : serial_channel

//--- verilog/serial_pins_pkg.sv
// Operation
// - Standard mode: transmit idles high, also in reset.
// - Infrared mode: encode/decode, transmit rests low.
// - Infrared receive rests low; software may invert it.
// - Clear-to-send is input or auto transmit gate.
// - Output-2 set: interrupt driven, port-2 pin low.
// - Output-2 clear: interrupt floats, port-2 pin high.
// - Terminal-ready is a software general output.
// - Set-ready, carrier, ring are readable inputs and change-event sources only.
// - Output-2 bit resets to zero.
// - In reset ignore receive, hold transmit high.
package serial_pins_pkg;

    // ****************************************************************
    // Register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] CHAN_A_BASE       = 8'h00;
    localparam logic [7:0] CHAN_B_BASE       = 8'h20;
    localparam logic [4:0] MODEM_CONTROL_OFS = 5'h00;
    localparam logic [4:0] FEATURE_OFS       = 5'h04;
    localparam logic [4:0] INT_ENABLE_OFS    = 5'h08;
    localparam logic [4:0] MODEM_STATUS_OFS  = 5'h0C;
    localparam logic [4:0] TX_DATA_OFS       = 5'h10;
    localparam logic [4:0] LINE_STATUS_OFS   = 5'h14;
    localparam logic [7:0] EVENT_STATUS_ADDR = 8'h40;
    localparam logic [7:0] EVENT_MASK_ADDR   = 8'h44;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MCR_DTR_BIT      = 0;
    localparam int MCR_RTS_BIT      = 1;
    localparam int MCR_OUT2_BIT     = 3;
    localparam int MCR_IR_BIT       = 6;
    localparam int EFR_RX_INV_BIT   = 0;
    localparam int EFR_RX_HOLD_BIT  = 1;
    localparam int EFR_AUTO_RTS_BIT = 6;
    localparam int EFR_AUTO_CTS_BIT = 7;
    localparam int IER_AUTO_RTS_BIT = 6;
    localparam int IER_AUTO_CTS_BIT = 7;
    localparam int EVENTS_PER_CHAN  = 5;
    localparam int CHAN_B_EVENT_POS = 8;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [7:0]  MODEM_CONTROL_RST = 8'h00;
    localparam logic [7:0]  FEATURE_RST       = 8'h00;
    localparam logic [7:0]  INT_ENABLE_RST    = 8'h00;
    localparam logic [15:0] EVENT_MASK_RST    = 16'h0000;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          RESET_MIN_NS      = 40;
    localparam int          RESET_MIN_CYCLES  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          BIT_CYCLES_DFLT   = 16;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic ir_select;
        logic rx_invert;
        logic out2;
        logic rts;
        logic dtr;
        logic auto_rts;
        logic auto_cts;
        logic rx_hold;
    } chan_ctrl_type;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic cd;
        logic ri;
    } modem_in_type;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

endpackage : serial_pins_pkg

//--- verilog/serial_pins_top.sv
`timescale 1ns/100ps
module serial_pins_top
    import serial_pins_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // AXI4-Lite write address
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Interrupt to the system
    output logic             IRQ,
    // Channel A pins
    output logic             CHAN_A_SERIAL_OUT,
    input  wire logic        CHAN_A_SERIAL_IN,
    output logic             CHAN_A_REQUEST_SEND_N,
    input  wire logic        CHAN_A_CLEAR_SEND_N,
    output logic             CHAN_A_TERMINAL_READY_N,
    input  wire logic        CHAN_A_SET_READY_N,
    input  wire logic        CHAN_A_CARRIER_DETECT_N,
    input  wire logic        CHAN_A_RING_INDICATE_N,
    output logic             CHAN_A_OUTPUT_PORT2_N,
    output logic             CHAN_A_INTERRUPT_OUT,
    output logic             CHAN_A_INTERRUPT_OE,
    // Channel B pins
    output logic             CHAN_B_SERIAL_OUT,
    input  wire logic        CHAN_B_SERIAL_IN,
    output logic             CHAN_B_REQUEST_SEND_N,
    input  wire logic        CHAN_B_CLEAR_SEND_N,
    output logic             CHAN_B_TERMINAL_READY_N,
    input  wire logic        CHAN_B_SET_READY_N,
    input  wire logic        CHAN_B_CARRIER_DETECT_N,
    input  wire logic        CHAN_B_RING_INDICATE_N,
    output logic             CHAN_B_OUTPUT_PORT2_N,
    output logic             CHAN_B_INTERRUPT_OUT,
    output logic             CHAN_B_INTERRUPT_OE
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic             aw_held;
        logic             w_held;
        logic [7:0]       aw_addr;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic [1:0][7:0]  modem_ctrl;
        logic [1:0][7:0]  feature;
        logic [1:0][7:0]  int_enable;
        logic [1:0][7:0]  tx_byte;
        logic [1:0]       tx_start;
        logic [1:0][3:0]  modem_prev;
        logic [15:0]      evt_status;
        logic [15:0]      evt_mask;
        logic             irq;
        logic [1:0]       chan_irq;
    } top_state_type;

    top_state_type  st_reg;
    top_state_type  st_next;

    chan_ctrl_type  [1:0] ctrl;
    modem_in_type   [1:0] modem_in;
    logic           [1:0] tx_busy;
    logic           [1:0] tx_done;
    logic           [1:0] rx_level;
    logic           [1:0] serial_in;
    logic           [1:0] serial_out;
    logic           [1:0] rts_n;
    logic           [1:0] cts_n;
    logic           [15:0] evt_set;
    logic           [15:0] evt_pending;

    assign serial_in = {CHAN_B_SERIAL_IN, CHAN_A_SERIAL_IN};
    assign cts_n     = {CHAN_B_CLEAR_SEND_N, CHAN_A_CLEAR_SEND_N};

    // Modem inputs feed status and events; clear-to-send also gates transmit.
    assign modem_in[0] = '{cts: !CHAN_A_CLEAR_SEND_N, dsr: !CHAN_A_SET_READY_N,
                           cd: !CHAN_A_CARRIER_DETECT_N, ri: !CHAN_A_RING_INDICATE_N};
    assign modem_in[1] = '{cts: !CHAN_B_CLEAR_SEND_N, dsr: !CHAN_B_SET_READY_N,
                           cd: !CHAN_B_CARRIER_DETECT_N, ri: !CHAN_B_RING_INDICATE_N};

    // ****************************************************************
    // Channel control decode
    // ****************************************************************
    for (genvar c = 0; c < 2; c++) begin : g_chan
        assign ctrl[c].ir_select = st_reg.modem_ctrl[c][MCR_IR_BIT];
        assign ctrl[c].rx_invert = st_reg.feature[c][EFR_RX_INV_BIT];
        assign ctrl[c].out2      = st_reg.modem_ctrl[c][MCR_OUT2_BIT];
        assign ctrl[c].rts       = st_reg.modem_ctrl[c][MCR_RTS_BIT];
        assign ctrl[c].dtr       = st_reg.modem_ctrl[c][MCR_DTR_BIT];
        // Auto flow needs the feature and the enable bit.
        assign ctrl[c].auto_rts  = st_reg.feature[c][EFR_AUTO_RTS_BIT]
                                 & st_reg.int_enable[c][IER_AUTO_RTS_BIT];
        assign ctrl[c].auto_cts  = st_reg.feature[c][EFR_AUTO_CTS_BIT]
                                 & st_reg.int_enable[c][IER_AUTO_CTS_BIT];
        assign ctrl[c].rx_hold   = st_reg.feature[c][EFR_RX_HOLD_BIT];

        serial_channel #(
            .BIT_CYCLES     (BIT_CYCLES)
        ) u_channel (
            .clk            (CLK),
            .rst            (SYS_RST),
            .ctrl           (ctrl[c]),
            .tx_start       (st_reg.tx_start[c]),
            .tx_byte        (st_reg.tx_byte[c]),
            .tx_busy        (tx_busy[c]),
            .tx_done        (tx_done[c]),
            .rx_level       (rx_level[c]),
            .serial_in      (serial_in[c]),
            .serial_out     (serial_out[c]),
            .request_send_n (rts_n[c]),
            .clear_send_n   (cts_n[c])
        );
    end

    // ****************************************************************
    // Event sources
    // ****************************************************************
    always_comb begin
        evt_set = 16'h0000;
        for (int c = 0; c < 2; c++) begin
            evt_set[c * CHAN_B_EVENT_POS +: EVENTS_PER_CHAN] =
                {tx_done[c], modem_in[c] ^ st_reg.modem_prev[c]};
        end
    end

    assign evt_pending = st_reg.evt_status & st_reg.evt_mask;

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    function automatic logic [32:0] read_reg(input top_state_type s, input logic [7:0] addr,
                                             input modem_in_type [1:0] mi,
                                             input logic [1:0] busy, input logic [1:0] rxl);
        logic [32:0] r;
        int          c;
        r = {1'b1, 32'h0000_0000};
        c = (addr >= CHAN_B_BASE) ? 1 : 0;
        if (addr == EVENT_STATUS_ADDR) begin
            r = {1'b0, 16'h0000, s.evt_status};
        end else if (addr == EVENT_MASK_ADDR) begin
            r = {1'b0, 16'h0000, s.evt_mask};
        end else if (addr < CHAN_B_BASE + 8'h20) begin
            unique case (addr[4:0] - (c == 1 ? CHAN_B_BASE[4:0] : CHAN_A_BASE[4:0]))
                MODEM_CONTROL_OFS: r = {1'b0, 24'h000000, s.modem_ctrl[c]};
                FEATURE_OFS:       r = {1'b0, 24'h000000, s.feature[c]};
                INT_ENABLE_OFS:    r = {1'b0, 24'h000000, s.int_enable[c]};
                MODEM_STATUS_OFS:  r = {1'b0, 24'h000000, s.modem_prev[c], mi[c]};
                TX_DATA_OFS:       r = {1'b0, 24'h000000, s.tx_byte[c]};
                LINE_STATUS_OFS:   r = {1'b0, 30'h00000000, rxl[c], busy[c]};
                default:           r = {1'b1, 32'h0000_0000};
            endcase
        end
        return r;
    endfunction : read_reg

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [32:0] rd;
        logic        wr_ok;
        int          c;
        st_next          = st_reg;
        rd               = 33'h0_0000_0000;
        wr_ok            = 1'b0;
        c                = 0;
        st_next.tx_start = 2'b00;

        // Address and data may come in either order.
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            st_next.w_held = 1'b1;
            st_next.w_data = S_AXI_WDATA;
            st_next.w_strb = S_AXI_WSTRB;
        end
        if (st_reg.bvalid && S_AXI_BREADY) begin
            st_next.bvalid = 1'b0;
        end

        // A set in the same cycle as a clear wins.
        for (int k = 0; k < 2; k++) begin
            st_next.modem_prev[k] = modem_in[k];
        end

        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            wr_ok           = 1'b1;
            c               = (st_reg.aw_addr >= CHAN_B_BASE) ? 1 : 0;
            if (st_reg.aw_addr == EVENT_STATUS_ADDR) begin
                if (st_reg.w_strb[0]) begin
                    st_next.evt_status[7:0] = st_reg.evt_status[7:0] & ~st_reg.w_data[7:0];
                end
                if (st_reg.w_strb[1]) begin
                    st_next.evt_status[15:8] = st_reg.evt_status[15:8] & ~st_reg.w_data[15:8];
                end
            end else if (st_reg.aw_addr == EVENT_MASK_ADDR) begin
                if (st_reg.w_strb[0]) begin
                    st_next.evt_mask[7:0] = st_reg.w_data[7:0];
                end
                if (st_reg.w_strb[1]) begin
                    st_next.evt_mask[15:8] = st_reg.w_data[15:8];
                end
            end else if (st_reg.aw_addr < CHAN_B_BASE + 8'h20) begin
                unique case (st_reg.aw_addr[4:0])
                    MODEM_CONTROL_OFS: begin
                        if (st_reg.w_strb[0]) begin
                            st_next.modem_ctrl[c] = st_reg.w_data[7:0];
                        end
                    end
                    FEATURE_OFS: begin
                        if (st_reg.w_strb[0]) begin
                            st_next.feature[c] = st_reg.w_data[7:0];
                        end
                    end
                    INT_ENABLE_OFS: begin
                        if (st_reg.w_strb[0]) begin
                            st_next.int_enable[c] = st_reg.w_data[7:0];
                        end
                    end
                    TX_DATA_OFS: begin
                        // A byte written while one is still waiting replaces it.
                        if (st_reg.w_strb[0]) begin
                            st_next.tx_byte[c]  = st_reg.w_data[7:0];
                            st_next.tx_start[c] = 1'b1;
                        end
                    end
                    MODEM_STATUS_OFS, LINE_STATUS_OFS: wr_ok = 1'b1;
                    default: wr_ok = 1'b0;
                endcase
            end else begin
                wr_ok = 1'b0;
            end
            st_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end

        st_next.evt_status = st_next.evt_status | evt_set;

        if (st_reg.rvalid && S_AXI_RREADY) begin
            st_next.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rd             = read_reg(st_reg, S_AXI_ARADDR, modem_in, tx_busy, rx_level);
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd[31:0];
            st_next.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
        end

        st_next.irq = |evt_pending;
        for (int k = 0; k < 2; k++) begin
            st_next.chan_irq[k] = |evt_pending[k * CHAN_B_EVENT_POS +: EVENTS_PER_CHAN];
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_reg            <= '0;
            st_reg.modem_ctrl <= {MODEM_CONTROL_RST, MODEM_CONTROL_RST};
            st_reg.feature    <= {FEATURE_RST, FEATURE_RST};
            st_reg.int_enable <= {INT_ENABLE_RST, INT_ENABLE_RST};
            st_reg.evt_mask   <= EVENT_MASK_RST;
            st_reg.modem_prev <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign S_AXI_AWREADY = !st_reg.aw_held && !st_reg.bvalid;
    assign S_AXI_WREADY  = !st_reg.w_held && !st_reg.bvalid;
    assign S_AXI_BVALID  = st_reg.bvalid;
    assign S_AXI_BRESP   = st_reg.bresp;
    assign S_AXI_ARREADY = !st_reg.rvalid;
    assign S_AXI_RVALID  = st_reg.rvalid;
    assign S_AXI_RDATA   = st_reg.rdata;
    assign S_AXI_RRESP   = st_reg.rresp;
    assign IRQ           = st_reg.irq;

    assign CHAN_A_SERIAL_OUT       = serial_out[0];
    assign CHAN_B_SERIAL_OUT       = serial_out[1];
    assign CHAN_A_REQUEST_SEND_N   = rts_n[0];
    assign CHAN_B_REQUEST_SEND_N   = rts_n[1];
    assign CHAN_A_TERMINAL_READY_N = !ctrl[0].dtr;
    assign CHAN_B_TERMINAL_READY_N = !ctrl[1].dtr;

    // Port-2 shares the enable bit, so it is no free output.
    assign CHAN_A_OUTPUT_PORT2_N   = !ctrl[0].out2;
    assign CHAN_B_OUTPUT_PORT2_N   = !ctrl[1].out2;
    assign CHAN_A_INTERRUPT_OE     = ctrl[0].out2;
    assign CHAN_B_INTERRUPT_OE     = ctrl[1].out2;
    assign CHAN_A_INTERRUPT_OUT    = st_reg.chan_irq[0];
    assign CHAN_B_INTERRUPT_OUT    = st_reg.chan_irq[1];

endmodule : serial_pins_top
